// File: rtl/mhcp_top.sv
// Motion host command port: APB slave, packet receiver, command and return FIFOs.
`include "mhcp_defines.svh"
module mhcp_top
(
  // Clock and reset.
  input  wire logic                 SYS_CLK,
  input  wire logic                 NRST,
  // APB slave.
  input  wire logic                 PSEL,
  input  wire logic                 PENABLE,
  input  wire logic                 PWRITE,
  input  wire logic [7:0]           PADDR,
  input  wire mhcp_pkg::mhcp_word_t PWDATA,
  output      mhcp_pkg::mhcp_word_t PRDATA,
  output logic                      PREADY,
  output logic                      PSLVERR,
  // Controller core side.
  input  wire logic [31:0]          AXIS_STATUS,
  input  wire logic                 CORE_READY,
  input  wire logic                 CORE_MODAL_ERR,
  input  wire logic                 RET_VALID,
  input  wire mhcp_pkg::mhcp_word_t RET_DATA,
  output logic                      CMD_EXEC,
  output logic                      CMD_STORE,
  output      mhcp_pkg::mhcp_cmd_t  CMD_WORD,
  // Interrupt.
  output logic                      IRQ
);
  import mhcp_pkg::*;

  // Pointer step shared by both FIFOs.
  function automatic logic [`MHCP_PTR_W-1:0] ptr_inc(input logic [`MHCP_PTR_W-1:0] p);
    ptr_inc = p + 4'h1;
  endfunction : ptr_inc

  // Decoded bus phases.
  logic             setup_c;   // Setup cycle of a transfer.
  logic             done_c;    // Completing access cycle.
  logic             wr_c;      // Write completing now.
  logic             rd_c;      // Read completing now.
  logic             hit_c;     // Address maps to a register.
  assign setup_c = PSEL & ~PENABLE;
  assign done_c  = PSEL & PENABLE & PREADY;
  assign wr_c    = done_c & PWRITE;
  assign rd_c    = done_c & ~PWRITE;
  assign hit_c   = (PADDR == `MHCP_DATA_OFS) || (PADDR == `MHCP_COMM_OFS) ||
                   (PADDR == `MHCP_MOTION_OFS) || (PADDR == `MHCP_IRQ_STAT_OFS) ||
                   (PADDR == `MHCP_IRQ_MASK_OFS) || (PADDR == `MHCP_CTRL_OFS);

  // Command FIFO storage and pointers.
  mhcp_cmd_t                cq_mem_q [16];  // Queued commands.
  logic [`MHCP_PTR_W-1:0]   cq_wr_q;        // Write index.
  logic [`MHCP_PTR_W-1:0]   cq_rd_q;        // Read index.
  logic [4:0]               cq_cnt_q;       // Entries held.
  logic                     cq_push_c;      // Commit a good packet.
  logic                     cq_pop_c;       // Processor takes the head.
  // Return FIFO storage and pointers.
  mhcp_word_t               rq_mem_q [16];  // Return words.
  logic [`MHCP_PTR_W-1:0]   rq_wr_q;        // Write index.
  logic [`MHCP_PTR_W-1:0]   rq_rd_q;        // Read index.
  logic [4:0]               rq_cnt_q;       // Entries held.
  logic                     rq_push_c;      // Store a return word.
  logic                     rq_pop_c;       // Host reads the data port.
  logic                     rq_ovf_c;       // Return word dropped.
  // Packet receiver.
  mhcp_state_t              st_q;           // Receiver state.
  mhcp_cmd_t                asm_q;          // Packet being assembled.
  logic [1:0]               need_q;         // Data words announced.
  logic [1:0]               got_q;          // Data words received.
  logic                     dwr_c;          // Host wrote the data port.
  logic                     frame_err_c;    // Framing error on this word.
  // Error flags and interrupt state.
  logic                     pkt_err_q;      // Packet error flag.
  logic                     err_msg_q;      // Error message flag.
  logic                     modal_c;        // Modal error this cycle.
  logic                     op_err_c;       // Popped command has a zero opcode.
  logic [`MHCP_EV_W-1:0]    ev_c;           // Events this cycle.
  logic [`MHCP_EV_W-1:0]    irq_stat_q;     // Sticky event bits.
  logic [`MHCP_EV_W-1:0]    irq_mask_q;     // Enable per event.
  logic [31:0]              comm_c;         // Communication status view.

  // Room for one more command keeps the host allowed to write.
  assign comm_c = {28'h0, err_msg_q, pkt_err_q, (rq_cnt_q != 5'h00),
                   (cq_cnt_q < `MHCP_DEPTH)};

  // APB answers every access in the cycle after setup, with no wait states.
  always_ff @(posedge SYS_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end
    else
    begin
      PREADY  <= setup_c;
      PSLVERR <= setup_c & ~hit_c;
    end
  end

  // Read data is captured in setup so it stands through the access phase.
  always_ff @(posedge SYS_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      PRDATA <= `MHCP_RESET_WORD;
    end
    else if (setup_c && !PWRITE)
    begin
      case (PADDR)
        `MHCP_DATA_OFS:     PRDATA <= (rq_cnt_q != 5'h00) ? rq_mem_q[rq_rd_q] : `MHCP_RESET_WORD;
        `MHCP_COMM_OFS:     PRDATA <= comm_c;
        `MHCP_MOTION_OFS:   PRDATA <= AXIS_STATUS;
        `MHCP_IRQ_STAT_OFS: PRDATA <= {28'h0, irq_stat_q};
        `MHCP_IRQ_MASK_OFS: PRDATA <= {28'h0, irq_mask_q};
        default:            PRDATA <= `MHCP_RESET_WORD;
      endcase
    end
  end

  // A write to the data port feeds the packet receiver.
  assign dwr_c = wr_c && (PADDR == `MHCP_DATA_OFS);

  // Packet receiver: identifier, command, data words, terminator.
  // A word written while the host may not write is a framing error; it cannot be queued.
  always_comb
  begin
    frame_err_c = 1'b0;
    cq_push_c   = 1'b0;
    if (dwr_c)
    begin
      if (cq_cnt_q == `MHCP_DEPTH)
      begin
        frame_err_c = 1'b1;
      end
      else
      begin
        case (st_q)
          MHCP_ST_IDLE: frame_err_c = (PWDATA[15:8] != `MHCP_ID_MARK) || (PWDATA[1:0] > `MHCP_MAX_DATA);
          MHCP_ST_TERM:
          begin
            frame_err_c = (PWDATA[15:0] != `MHCP_TERM_WORD);
            cq_push_c   = (PWDATA[15:0] == `MHCP_TERM_WORD);
          end
          default:      frame_err_c = 1'b0;
        endcase
      end
    end
  end

  // Receiver state; any framing error drops the partial packet.
  always_ff @(posedge SYS_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      st_q   <= MHCP_ST_IDLE;
      asm_q  <= 48'h0;
      need_q <= 2'h0;
      got_q  <= 2'h0;
    end
    else if (frame_err_c)
    begin
      st_q <= MHCP_ST_IDLE;
    end
    else if (dwr_c)
    begin
      case (st_q)
        MHCP_ST_IDLE:
        begin
          need_q <= PWDATA[1:0];
          got_q  <= 2'h0;
          asm_q  <= 48'h0;
          st_q   <= MHCP_ST_CMD;
        end
        MHCP_ST_CMD:
        begin
          asm_q[47:32] <= PWDATA[15:0];
          st_q         <= (need_q == 2'h0) ? MHCP_ST_TERM : MHCP_ST_DATA;
        end
        MHCP_ST_DATA:
        begin
          if (got_q == 2'h0)
          begin
            asm_q[31:16] <= PWDATA[15:0];
          end
          else
          begin
            asm_q[15:0] <= PWDATA[15:0];
          end
          got_q <= got_q + 2'h1;
          st_q  <= (got_q + 2'h1 == need_q) ? MHCP_ST_TERM : MHCP_ST_DATA;
        end
        MHCP_ST_TERM: st_q <= MHCP_ST_IDLE;
        default:      st_q <= MHCP_ST_IDLE;
      endcase
    end
  end

  // Command FIFO: sixteen entries, taken out in arrival order.
  always_ff @(posedge SYS_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      cq_wr_q  <= 4'h0;
      cq_rd_q  <= 4'h0;
      cq_cnt_q <= 5'h00;
    end
    else
    begin
      if (cq_push_c)
      begin
        cq_wr_q <= ptr_inc(cq_wr_q);
      end
      if (cq_pop_c)
      begin
        cq_rd_q <= ptr_inc(cq_rd_q);
      end
      cq_cnt_q <= cq_cnt_q + {4'h0, cq_push_c} - {4'h0, cq_pop_c};
    end
  end

  // Command storage carries no reset; entries are valid only below the count.
  always_ff @(posedge SYS_CLK)
  begin
    if (cq_push_c)
    begin
      cq_mem_q[cq_wr_q] <= asm_q;
    end
  end

  // Processor takes one command whenever the core can accept one.
  assign cq_pop_c = CORE_READY && (cq_cnt_q != 5'h00);
  // An all-zero opcode is a data error; that command alone is not dispatched.
  assign op_err_c = cq_pop_c && (cq_mem_q[cq_rd_q][39:32] == 8'h00);
  // A core error only raises the flag, so a good command popped beside it is still dispatched.
  assign modal_c  = op_err_c || CORE_MODAL_ERR;

  // Dispatch: execute now or store in the onboard program.
  always_ff @(posedge SYS_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      CMD_EXEC  <= 1'b0;
      CMD_STORE <= 1'b0;
      CMD_WORD  <= 48'h0;
    end
    else
    begin
      CMD_EXEC  <= cq_pop_c && !op_err_c && !cq_mem_q[cq_rd_q][32+`MHCP_CMD_STORE_BIT];
      CMD_STORE <= cq_pop_c && !op_err_c && cq_mem_q[cq_rd_q][32+`MHCP_CMD_STORE_BIT];
      if (cq_pop_c)
      begin
        CMD_WORD <= cq_mem_q[cq_rd_q];
      end
    end
  end

  // Return FIFO: sixteen deep; a word that finds it full is dropped.
  assign rq_pop_c  = rd_c && (PADDR == `MHCP_DATA_OFS) && (rq_cnt_q != 5'h00);
  assign rq_push_c = RET_VALID && (rq_cnt_q != `MHCP_DEPTH);
  assign rq_ovf_c  = RET_VALID && (rq_cnt_q == `MHCP_DEPTH);
  always_ff @(posedge SYS_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      rq_wr_q  <= 4'h0;
      rq_rd_q  <= 4'h0;
      rq_cnt_q <= 5'h00;
    end
    else
    begin
      if (rq_push_c)
      begin
        rq_wr_q <= ptr_inc(rq_wr_q);
      end
      if (rq_pop_c)
      begin
        rq_rd_q <= ptr_inc(rq_rd_q);
      end
      rq_cnt_q <= rq_cnt_q + {4'h0, rq_push_c} - {4'h0, rq_pop_c};
    end
  end

  // Return storage carries no reset, like the command storage.
  always_ff @(posedge SYS_CLK)
  begin
    if (rq_push_c)
    begin
      rq_mem_q[rq_wr_q] <= RET_DATA;
    end
  end

  // Error flags are sticky; a new error wins over a clear in the same cycle.
  always_ff @(posedge SYS_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      pkt_err_q <= 1'b0;
      err_msg_q <= 1'b0;
    end
    else
    begin
      if (frame_err_c)
      begin
        pkt_err_q <= 1'b1;
      end
      else if (wr_c && (PADDR == `MHCP_CTRL_OFS) && PWDATA[`MHCP_CTRL_CLR_PKT])
      begin
        pkt_err_q <= 1'b0;
      end
      if (modal_c || rq_ovf_c)
      begin
        err_msg_q <= 1'b1;
      end
      else if (wr_c && (PADDR == `MHCP_CTRL_OFS) && PWDATA[`MHCP_CTRL_CLR_MSG])
      begin
        err_msg_q <= 1'b0;
      end
    end
  end

  // Interrupt events, write-one-to-clear status, mask, one level output.
  assign ev_c = {rq_push_c, rq_ovf_c, modal_c, frame_err_c};
  always_ff @(posedge SYS_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      irq_stat_q <= 4'h0;
      irq_mask_q <= 4'h0;
      IRQ        <= 1'b0;
    end
    else
    begin
      if (wr_c && (PADDR == `MHCP_IRQ_STAT_OFS))
      begin
        irq_stat_q <= (irq_stat_q & ~PWDATA[3:0]) | ev_c;
      end
      else
      begin
        irq_stat_q <= irq_stat_q | ev_c;
      end
      if (wr_c && (PADDR == `MHCP_IRQ_MASK_OFS))
      begin
        irq_mask_q <= PWDATA[3:0];
      end
      // Output follows the registered status one cycle later.
      IRQ <= |(irq_stat_q & irq_mask_q);
    end
  end

  // Checks on the behaviour above.
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);

  // A framing error is followed by the packet error flag.
  sequence s_bad_word;
    frame_err_c;
  endsequence
  sequence s_pkt_flagged;
    ##1 pkt_err_q;
  endsequence

  AST_PKTERR_SET: assert property (s_bad_word |-> s_pkt_flagged)
    else $error("Packet error flag not set after framing error.");
  AST_NO_PUSH_ON_ERR: assert property (frame_err_c |-> !cq_push_c)
    else $error("Command queued from a bad packet.");
  AST_CQ_BOUND: assert property (cq_cnt_q <= `MHCP_DEPTH)
    else $error("Command FIFO count above sixteen.");
  AST_MAYWR_FULL: assert property ((cq_cnt_q == `MHCP_DEPTH) |-> !comm_c[`MHCP_COMM_MAYWR])
    else $error("May-write flag set with command FIFO full.");
  AST_MAYWR_ROOM: assert property ($fell(cq_cnt_q == `MHCP_DEPTH) |-> comm_c[`MHCP_COMM_MAYWR])
    else $error("May-write flag not back with room.");
  AST_DISPATCH: assert property (cq_pop_c && !op_err_c |=> CMD_EXEC ^ CMD_STORE)
    else $error("Command neither executed nor stored.");
  AST_MODAL: assert property (modal_c |=> err_msg_q && !($past(op_err_c) && (CMD_EXEC || CMD_STORE)))
    else $error("Modal error not flagged.");
  AST_RDAVAIL: assert property (rq_push_c |=> comm_c[`MHCP_COMM_RDAVAIL])
    else $error("Return data flag missing.");
  AST_RETOVF: assert property (rq_ovf_c && !rq_pop_c |=> err_msg_q && rq_cnt_q == `MHCP_DEPTH)
    else $error("Return overflow not handled.");
  AST_STICKY: assert property (pkt_err_q && !wr_c |=> pkt_err_q)
    else $error("Packet error flag cleared without host action.");
  AST_RO_STATUS: assert property (wr_c && PADDR == `MHCP_COMM_OFS && !frame_err_c |=> $stable(pkt_err_q))
    else $error("Write changed communication status.");
endmodule : mhcp_top

// File: rtl/mhcp_defines.svh
// Offsets, field positions, reset values and sizes of the motion host command port.
`ifndef MHCP_DEFINES_SVH
`define MHCP_DEFINES_SVH
// Byte addresses of the APB registers.
`define MHCP_DATA_OFS      8'h00
`define MHCP_COMM_OFS      8'h04
`define MHCP_MOTION_OFS    8'h08
`define MHCP_IRQ_STAT_OFS  8'h0C
`define MHCP_IRQ_MASK_OFS  8'h10
`define MHCP_CTRL_OFS      8'h14
// Bits of the communication status register.
`define MHCP_COMM_MAYWR    0
`define MHCP_COMM_RDAVAIL  1
`define MHCP_COMM_PKTERR   2
`define MHCP_COMM_ERRMSG   3
// Bits of the control register, write-only strobes.
`define MHCP_CTRL_CLR_PKT  0
`define MHCP_CTRL_CLR_MSG  1
// Interrupt event bits, shared by status and mask.
`define MHCP_EV_PKTERR     0
`define MHCP_EV_MODAL      1
`define MHCP_EV_RETOVF     2
`define MHCP_EV_RETDATA    3
`define MHCP_EV_W          4
// Packet framing: identifier mark in bits 15:8, data count in bits 1:0.
`define MHCP_ID_MARK       8'hA5
`define MHCP_TERM_WORD     16'h5AFF
`define MHCP_MAX_DATA      2'h2
// Command word: bit 15 asks for storage in the onboard program.
`define MHCP_CMD_STORE_BIT 15
// Both FIFOs hold 16 entries.
`define MHCP_DEPTH         5'h10
`define MHCP_PTR_W         4
`define MHCP_RESET_WORD    32'h0000_0000
`endif

// File: rtl/mhcp_pkg.sv
// Types shared by the motion host command port.
package mhcp_pkg;
  // One bus word.
  typedef logic [31:0] mhcp_word_t;
  // One queued command: command word and two data words.
  typedef logic [47:0] mhcp_cmd_t;
  // Packet receiver states, one-hot.
  typedef enum logic [3:0]
  {
    MHCP_ST_IDLE = 4'h1,
    MHCP_ST_CMD  = 4'h2,
    MHCP_ST_DATA = 4'h4,
    MHCP_ST_TERM = 4'h8
  } mhcp_state_t;
endpackage : mhcp_pkg

// File: verif/mhcp_core_model.sv
// Controller core model: takes dispatched commands, returns words, shows axis status, raises modal errors.
module mhcp_core_model
(
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        nrst,
  // Dispatch from the port.
  input  wire logic        cmd_exec,
  input  wire logic        cmd_store,
  input  wire logic [47:0] cmd_word,
  // Core side driven into the port.
  output logic             core_ready,
  output logic             modal_err,
  output logic             ret_valid,
  output logic [31:0]      ret_data,
  output logic [31:0]      axis_status
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        hold = 1'B0;      // The bench sets this to stall the core.
  logic [48:0] got[$];           // Dispatched commands, store flag on top.
  initial
  begin
    modal_err = 1'B0;
    ret_valid = 1'B0;
    ret_data = 32'hDEAD_BEEF;
    axis_status = 32'h0;
  end
  // A stalled core refuses new commands, so the command queue backs up.
  assign core_ready = ~hold;
  // Every dispatch strobe is recorded with its kind for later comparison.
  always @(posedge clk)
  begin
    if (nrst && (cmd_exec || cmd_store))
    begin
      got.push_back({cmd_store, cmd_word});
    end
  end
  // One return word valid for one cycle; data is inverted afterwards so stale data never looks valid.
  task automatic send_ret(input logic [31:0] w);
    ret_valid <= 1'B1;
    ret_data <= w;
    @(posedge clk);
    ret_valid <= 1'B0;
    ret_data <= ~w;
    @(posedge clk);
  endtask : send_ret
  // A one-cycle sequence error from the core.
  task automatic modal_pulse();
    modal_err <= 1'B1;
    @(posedge clk);
    modal_err <= 1'B0;
    @(posedge clk);
  endtask : modal_pulse
endmodule : mhcp_core_model

// File: verif/mhcp_top_tb_top.sv
// Self-checking bench of the motion host command port.
`include "mhcp_defines.svh"
module mhcp_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import mhcp_pkg::*;
  localparam logic [7:0] a_dat = `MHCP_DATA_OFS;      // Packet and return word port.
  localparam logic [7:0] a_com = `MHCP_COMM_OFS;      // Communication status.
  localparam logic [7:0] a_mot = `MHCP_MOTION_OFS;    // Axis motion status.
  localparam logic [7:0] a_ist = `MHCP_IRQ_STAT_OFS;  // Interrupt status.
  localparam logic [7:0] a_msk = `MHCP_IRQ_MASK_OFS;  // Interrupt mask.
  localparam logic [7:0] a_ctl = `MHCP_CTRL_OFS;      // Error clear strobes.
  logic       sys_clk = 1'B0;   // Bench clock.
  logic       nrst    = 1'B0;   // Reset, active low.
  logic       psel    = 1'B0;   // APB select.
  logic       penable = 1'B0;   // APB enable.
  logic       pwrite  = 1'B0;   // APB direction.
  logic [7:0] paddr   = 8'h00;  // APB address.
  mhcp_word_t pwdata  = 32'h0;  // APB write data.
  mhcp_word_t prdata, rdat, ret_data, axis_status;
  logic       pready, pslverr, rerr, core_ready, modal_err, ret_valid, cmd_exec, cmd_store, irq;
  mhcp_cmd_t  cmd_word;         // Dispatched command.
  int         fails = 0;        // Mismatches seen.
  int         cmp_count = 0;    // Comparisons made.
  // The clock toggles every half period of 5 ns.
  always #5 sys_clk = ~sys_clk;
  mhcp_top DUT (.SYS_CLK(sys_clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .AXIS_STATUS(axis_status), .CORE_READY(core_ready), .CORE_MODAL_ERR(modal_err), .RET_VALID(ret_valid),
    .RET_DATA(ret_data), .CMD_EXEC(cmd_exec), .CMD_STORE(cmd_store), .CMD_WORD(cmd_word), .IRQ(irq));
  mhcp_core_model core (.clk(sys_clk), .nrst(nrst), .cmd_exec(cmd_exec), .cmd_store(cmd_store),
    .cmd_word(cmd_word), .core_ready(core_ready), .modal_err(modal_err), .ret_valid(ret_valid),
    .ret_data(ret_data), .axis_status(axis_status));
  // Prints the verdict and ends the run.
  task automatic stop_test();
    if (fails == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test
  // Case inequality so that an unknown never passes.
  task automatic chk(input string nm, input logic [48:0] exp, input logic [48:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // One APB transfer; a spare edge at the end keeps two transfers from driving in one time step.
  task automatic apb(input logic wr, input logic [7:0] a, input mhcp_word_t wd);
    psel <= 1'B1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'B1;
    // Only the watchdog ends a wait for the answer.
    do
    begin
      @(posedge sys_clk);
    end
    while (pready !== 1'B1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'B0;
    penable <= 1'B0;
    @(posedge sys_clk);
  endtask : apb
  // Reads a register and compares it.
  task automatic rdchk(input string nm, input logic [7:0] a, input mhcp_word_t exp);
    apb(1'B0, a, 32'h0);
    chk(nm, {17'h0, exp}, {17'h0, rdat});
  endtask : rdchk
  // One packet word; a polite host first polls the may-write flag.
  task automatic put(input logic [15:0] w, input bit poll);
    while (poll)
    begin
      apb(1'B0, a_com, 32'h0);
      if (rdat[`MHCP_COMM_MAYWR] === 1'B1)
        break;
    end
    apb(1'B1, a_dat, {16'h0, w});
  endtask : put
  // Whole packet: identifier, command, data words, terminator.
  task automatic pkt(input logic [1:0] n, input logic [15:0] cmd, d0, d1, term, input logic [7:0] mk);
    put({mk, 6'h00, n}, 1'B1);
    put(cmd, 1'B1);
    if (n > 2'h0)
      put(d0, 1'B1);
    if (n > 2'h1)
      put(d1, 1'B1);
    put(term, 1'B1);
  endtask : pkt
  // Waits, bounded, until the core has taken k commands, then lets stray pulses show up.
  task automatic wait_disp(input int k);
    int n;
    n = 0;
    while (core.got.size() < k && n < 200)
    begin
      @(posedge sys_clk);
      n++;
    end
    repeat (4) @(posedge sys_clk);
  endtask : wait_disp
  // Status reads after reset, read-only places, live axis status, unmapped address.
  task automatic t_regs();
    core.axis_status <= 32'h1234_5678;
    @(posedge sys_clk);
    rdchk("comm", a_com, 32'h1);
    rdchk("motion", a_mot, 32'h1234_5678);
    core.axis_status <= 32'hCAFE_0001;
    apb(1'B1, a_mot, 32'hFFFF_FFFF);
    apb(1'B1, a_com, 32'hFFFF_FFFF);
    rdchk("motion live", a_mot, 32'hCAFE_0001);
    rdchk("comm ro", a_com, 32'h1);
    apb(1'B0, 8'h18, 32'h0);
    chk("unmapped err", 49'h1, {48'h0, rerr});
    chk("unmapped data", 49'h0, {17'h0, rdat});
  endtask : t_regs
  // Good packets of every length, one asking for storage.
  task automatic t_good();
    core.got.delete();
    pkt(2'h2, 16'h8011, 16'hA1B2, 16'hC3D4, `MHCP_TERM_WORD, `MHCP_ID_MARK);
    pkt(2'h1, 16'h0022, 16'h0E0F, 16'hFFFF, `MHCP_TERM_WORD, `MHCP_ID_MARK);
    pkt(2'h0, 16'h0033, 16'hFFFF, 16'hFFFF, `MHCP_TERM_WORD, `MHCP_ID_MARK);
    wait_disp(3);
    chk("dispatch count", 49'h3, core.got.size());
    chk("store cmd", {1'B1, 48'h8011_A1B2_C3D4}, core.got[0]);
    chk("exec one", {1'B0, 48'h0022_0E0F_0000}, core.got[1]);
    chk("exec none", {1'B0, 48'h0033_0000_0000}, core.got[2]);
  endtask : t_good
  // Bad mark, too many data words, wrong terminator; the first also drives the interrupt.
  task automatic t_bad();
    logic [7:0]  mk[3] = '{8'h5A, `MHCP_ID_MARK, `MHCP_ID_MARK};
    logic [1:0]  nn[3] = '{2'h0, 2'h3, 2'h0};
    logic [15:0] tm[3] = '{`MHCP_TERM_WORD, `MHCP_TERM_WORD, 16'h5AFE};
    core.got.delete();
    for (int i = 0; i < 3; i++)
    begin
      pkt(nn[i], 16'h0044, 16'h0101, 16'h0202, tm[i], mk[i]);
      rdchk("comm pkt err", a_com, 32'h5);
      rdchk("comm sticky", a_com, 32'h5);
      if (i == 0)
      begin
        rdchk("irq stat pkt", a_ist, 32'h1);
        apb(1'B1, a_msk, 32'h1);
        repeat (2) @(posedge sys_clk);
        chk("irq on", 49'h1, {48'h0, irq});
        apb(1'B1, a_ist, 32'h1);
        repeat (2) @(posedge sys_clk);
        chk("irq cleared", 49'h0, {48'h0, irq});
        apb(1'B1, a_msk, 32'h0);
      end
      apb(1'B1, a_ctl, 32'h1);
      rdchk("comm clear", a_com, 32'h1);
    end
    wait_disp(0);
    chk("bad queued", 49'h0, core.got.size());
    apb(1'B1, a_ist, 32'hF);
  endtask : t_bad
  // Stalled core: sixteen commands fit, the first word of a seventeenth packet is refused, order is kept.
  task automatic t_full();
    core.got.delete();
    core.hold <= 1'B1;
    for (int i = 0; i < 16; i++)
    begin
      pkt(2'h0, 16'h0001 + i[15:0], 16'h0, 16'h0, `MHCP_TERM_WORD, `MHCP_ID_MARK);
      if (i == 14)
        rdchk("comm room", a_com, 32'h1);
    end
    rdchk("comm full", a_com, 32'h0);
    put({`MHCP_ID_MARK, 8'h00}, 1'B0);
    rdchk("comm refused", a_com, 32'h4);
    apb(1'B1, a_ctl, 32'h1);
    apb(1'B1, a_ist, 32'hF);
    core.hold <= 1'B0;
    wait_disp(16);
    chk("full count", 49'h10, core.got.size());
    for (int i = 0; i < 16; i++)
      chk("order", {1'B0, 16'h0001 + i[15:0], 32'h0}, core.got[i]);
    rdchk("comm drained", a_com, 32'h1);
  endtask : t_full
  // Seventeen return words: one overflows; the rest come back in order.
  task automatic t_ret();
    for (int i = 0; i < 17; i++)
      core.send_ret(32'h100 + i);
    rdchk("comm ret", a_com, 32'hB);
    rdchk("irq stat ret", a_ist, 32'hC);
    apb(1'B1, a_msk, 32'h4);
    repeat (2) @(posedge sys_clk);
    chk("irq ovf", 49'h1, {48'h0, irq});
    for (int i = 0; i < 16; i++)
      rdchk("ret word", a_dat, 32'h100 + i);
    rdchk("comm empty", a_com, 32'h9);
    rdchk("ret empty", a_dat, 32'h0);
    apb(1'B1, a_ctl, 32'h2);
    apb(1'B1, a_ist, 32'hF);
    apb(1'B1, a_msk, 32'h0);
    repeat (2) @(posedge sys_clk);
    chk("irq off", 49'h0, {48'h0, irq});
  endtask : t_ret
  // Zero opcode and a core-reported error both set the error message bit; only the zero opcode command is not dispatched.
  task automatic t_modal();
    core.got.delete();
    pkt(2'h0, 16'h0100, 16'h0, 16'h0, `MHCP_TERM_WORD, `MHCP_ID_MARK);
    wait_disp(0);
    rdchk("comm modal", a_com, 32'h9);
    chk("modal no pulse", 49'h0, core.got.size());
    apb(1'B1, a_ctl, 32'h2);
    rdchk("comm msg clr", a_com, 32'h1);
    core.got.delete();
    core.hold <= 1'B1;
    pkt(2'h0, 16'h0055, 16'h0, 16'h0, `MHCP_TERM_WORD, `MHCP_ID_MARK);
    core.hold <= 1'B0;
    core.modal_pulse();
    wait_disp(1);
    chk("dispatch beside core err", {1'B0, 48'h0055_0000_0000}, core.got[0]);
    rdchk("comm core err", a_com, 32'h9);
    rdchk("irq stat modal", a_ist, 32'h2);
  endtask : t_modal
  // Main sequence: reset for four cycles, then every scenario in turn.
  initial
  begin
    repeat (4) @(posedge sys_clk);
    nrst <= 1'B1;
    @(posedge sys_clk);
    t_regs();
    t_good();
    t_bad();
    t_full();
    t_ret();
    t_modal();
    stop_test();
  end
  // Watchdog well beyond the expected run of under a thousand cycles.
  initial
  begin
    #200_000;
    fails++;
    stop_test();
  end
endmodule : mhcp_top_tb_top
